// file: rtl/eprg_ctrl.sv
// Purpose: Host controller for a 64K x 8 UV EPROM: read, identify, program
// Assumes: Pin inputs synchronous to i_sys_clk; level shifters drive HV
// Notes:   High voltages appear as separate qualifier outputs
`timescale 1ns/1ps
`default_nettype none
`include "eprg_regs.svh"
module eprg_ctrl
    import eprg_pkg::*;
#(
    parameter int AW         = 16,
    parameter int DW         = 8,
    parameter int PULSE_CYC  = `EPRG_PULSE_CYC,
    parameter int OVER_CYC   = `EPRG_OVER_CYC
) (
    input  wire logic          i_sys_clk,
    input  wire logic          i_rst_n,
    input  wire logic          i_start,
    input  wire eprg_pkg::eprg_op_t i_op,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [AW-1:0] i_last_addr,
    input  wire logic [DW-1:0] i_wdata,
    input  wire logic [DW-1:0] i_data_pins_in,
    output logic               o_busy,
    output logic               o_done,
    output eprg_pkg::eprg_res_t o_result,
    output logic [DW-1:0]      o_rdata,
    output logic               o_rdata_parity_ok,
    output logic [AW-1:0]      o_cur_addr,
    output logic               o_wdata_req,
    output logic [AW-1:0]      o_address_lines,
    output logic               o_chip_select_program_strobe_n,
    output logic               o_output_gate_n,
    output logic               o_output_gate_vpp,
    output logic               o_identifier_select_hv,
    output logic [DW-1:0]      o_data_pins_out,
    output logic               o_data_pins_oe
);
    import eprg_pkg::*;
    localparam int TW = 16;
    localparam logic [TW-1:0] ACC_C   = TW'(`EPRG_ACC_CYC);
    localparam logic [TW-1:0] SETUP_C = TW'(`EPRG_SETUP_CYC);
    localparam logic [TW-1:0] PULSE_C = TW'(PULSE_CYC);
    localparam logic [TW-1:0] OVER_C  = TW'(OVER_CYC);
    localparam logic [4:0]    MAXP    = 5'(`EPRG_MAX_PULSES);

    typedef enum logic [3:0] {
        S_IDLE, S_RD_WAIT, S_RD_DONE, S_SETUP, S_PULSE,
        S_VFY, S_VFY_CHK, S_NEXT, S_DONE
    } eprg_state_t;
    typedef enum logic [1:0] { P_ONE, P_OVER, P_FINAL } eprg_phase_t;

    eprg_state_t state_reg, state_next;
    eprg_phase_t phase_reg;
    eprg_op_t    op_reg;
    logic [AW-1:0] addr_reg, last_reg;
    logic [DW-1:0] wbyte_reg;
    logic [4:0]    pulses_reg;
    logic          fail_reg;
    logic          tm_load, tm_done;
    logic [TW-1:0] tm_count;

    function automatic logic odd_parity(input logic [DW-1:0] d);
        return ^d;
    endfunction : odd_parity

    // ************************************************************
    // Timer
    // ************************************************************
    eprg_timer #(.W(TW)) u_timer (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_load    (tm_load),
        .i_count   (tm_count),
        .o_busy    (),
        .o_done    (tm_done)
    );

    // ************************************************************
    // Sequencer
    // ************************************************************
    logic vfy_ok;
    assign vfy_ok = (i_data_pins_in == wbyte_reg);

    always_comb begin
        state_next = state_reg;
        tm_load    = 1'b0;
        tm_count   = ACC_C;
        unique case (state_reg)
            S_IDLE: begin
                if (i_start) begin
                    tm_load = 1'b1;
                    if (i_op == EPRG_OP_PROGRAM) begin
                        tm_count   = SETUP_C;
                        state_next = S_SETUP;
                    end else begin
                        state_next = S_RD_WAIT;
                    end
                end
            end
            S_RD_WAIT: if (tm_done) state_next = S_RD_DONE;
            S_RD_DONE: state_next = S_DONE;
            S_SETUP: begin
                if (tm_done) begin
                    tm_load    = 1'b1;
                    tm_count   = (phase_reg == P_OVER) ? OVER_C : PULSE_C;
                    state_next = (phase_reg == P_FINAL) ? S_VFY : S_PULSE;
                    if (phase_reg == P_FINAL) tm_count = ACC_C;
                end
            end
            S_PULSE: begin
                if (tm_done) begin
                    tm_load    = 1'b1;
                    tm_count   = ACC_C;
                    state_next = (phase_reg == P_OVER) ? S_NEXT : S_VFY;
                end
            end
            S_VFY: if (tm_done) state_next = S_VFY_CHK;
            S_VFY_CHK: begin
                if (vfy_ok || phase_reg == P_FINAL) begin
                    state_next = S_NEXT;
                end else if (pulses_reg >= MAXP) begin
                    state_next = S_DONE;
                end else begin
                    tm_load    = 1'b1;
                    tm_count   = SETUP_C;
                    state_next = S_SETUP;
                end
            end
            S_NEXT: begin
                if (addr_reg == last_reg && phase_reg == P_FINAL) begin
                    state_next = S_DONE;
                end else begin
                    tm_load    = 1'b1;
                    tm_count   = SETUP_C;
                    state_next = S_SETUP;
                end
            end
            S_DONE: state_next = S_IDLE;
            default: state_next = S_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= S_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            op_reg    <= EPRG_OP_READ;
            addr_reg  <= '0;
            last_reg  <= '0;
            phase_reg <= P_ONE;
        end else if (state_reg == S_IDLE && i_start) begin
            op_reg    <= i_op;
            addr_reg  <= i_addr;
            last_reg  <= i_last_addr;
            phase_reg <= P_ONE;
        end else if (state_reg == S_NEXT) begin
            if (addr_reg == last_reg) begin
                addr_reg  <= i_addr;
                phase_reg <= (phase_reg == P_ONE) ? P_OVER : P_FINAL;
            end else begin
                addr_reg <= addr_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wbyte_reg <= `EPRG_ERASED_BYTE;
        end else if ((state_reg == S_IDLE && i_start) || state_reg == S_NEXT) begin
            wbyte_reg <= i_wdata;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pulses_reg <= '0;
        end else if (state_reg == S_IDLE || state_reg == S_NEXT) begin
            pulses_reg <= '0;
        end else if (state_reg == S_PULSE && tm_done) begin
            pulses_reg <= pulses_reg + 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fail_reg <= 1'b0;
            o_result <= EPRG_RES_OK;
        end else if (state_reg == S_IDLE && i_start) begin
            fail_reg <= 1'b0;
        end else if (state_reg == S_VFY_CHK && !vfy_ok) begin
            if (phase_reg == P_FINAL) fail_reg <= 1'b1;
            else if (pulses_reg >= MAXP) o_result <= EPRG_RES_FAIL_PASS1;
        end else if (state_reg == S_NEXT && state_next == S_DONE) begin
            o_result <= fail_reg ? EPRG_RES_FAIL_FINAL : EPRG_RES_OK;
        end else if (state_reg == S_RD_DONE) begin
            o_result <= EPRG_RES_OK;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata           <= '0;
            o_rdata_parity_ok <= 1'b0;
        end else if (state_reg == S_RD_DONE || state_reg == S_VFY_CHK) begin
            o_rdata           <= i_data_pins_in;
            o_rdata_parity_ok <= odd_parity(i_data_pins_in);
        end
    end

    // ************************************************************
    // Pin drive
    // ************************************************************
    logic rd_cyc, pgm_cyc, id_cyc;
    assign rd_cyc  = state_reg inside {S_RD_WAIT, S_RD_DONE, S_VFY, S_VFY_CHK};
    assign pgm_cyc = state_reg inside {S_SETUP, S_PULSE};
    assign id_cyc  = op_reg == EPRG_OP_IDENT && state_reg != S_IDLE
                     && state_reg != S_DONE;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_address_lines                <= '0;
            o_chip_select_program_strobe_n <= 1'b1;
            o_output_gate_n                <= 1'b1;
            o_output_gate_vpp              <= 1'b0;
            o_identifier_select_hv         <= 1'b0;
            o_data_pins_out                <= '0;
            o_data_pins_oe                 <= 1'b0;
        end else begin
            o_address_lines <= id_cyc
                ? {{(AW-1){1'b0}}, addr_reg[0]} : addr_reg;
            o_identifier_select_hv <= id_cyc;
            o_output_gate_vpp <= pgm_cyc;
            o_output_gate_n   <= !rd_cyc;
            o_chip_select_program_strobe_n <=
                !(rd_cyc || (state_reg == S_PULSE && !tm_done));
            o_data_pins_out <= wbyte_reg;
            o_data_pins_oe  <= pgm_cyc;
        end
    end

    assign o_busy      = state_reg != S_IDLE;
    assign o_done      = state_reg == S_DONE;
    assign o_cur_addr  = addr_reg;
    assign o_wdata_req = state_reg == S_NEXT || state_reg == S_IDLE;

    // ************************************************************
    // Checks
    // ************************************************************
    chk_no_contention: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        o_data_pins_oe |-> o_output_gate_n)
        else $error("data driven while gate low");
    chk_pgm_needs_vpp: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (!o_chip_select_program_strobe_n && o_output_gate_n)
        |-> (o_output_gate_vpp && o_data_pins_oe))
        else $error("program strobe without supply or data");
    chk_id_addr_low: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        o_identifier_select_hv |-> (o_address_lines[AW-1:1] == '0))
        else $error("identify with upper address bits set");
    chk_pulse_limit: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        pulses_reg <= MAXP)
        else $error("too many pulses on one address");
    chk_pulse_width: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        ($rose(state_reg == S_PULSE) && phase_reg == P_ONE)
        |-> (state_reg == S_PULSE) [*8])
        else $error("program pulse too short");
    chk_verify_after: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        ($fell(state_reg == S_PULSE) && phase_reg == P_ONE)
        |-> state_reg == S_VFY)
        else $error("no verify after pulse");
    chk_vpp_off_read: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        !o_output_gate_n |-> !o_output_gate_vpp)
        else $error("supply on while reading");
    chk_read_delay: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (state_reg == S_IDLE && i_start && i_op != EPRG_OP_PROGRAM)
        |-> ##1 (state_reg == S_RD_WAIT) [*3])
        else $error("read sampled too early");
endmodule : eprg_ctrl
`default_nettype wire

// file: rtl/eprg_pkg.sv
// Purpose: Types for the EPROM programming controller
// Assumes: Nothing beyond the constants header
// Notes:   Operation and result encodings
package eprg_pkg;
    typedef enum logic [1:0] {
        EPRG_OP_READ,
        EPRG_OP_PROGRAM,
        EPRG_OP_IDENT
    } eprg_op_t;
    typedef enum logic [1:0] {
        EPRG_RES_OK,
        EPRG_RES_FAIL_PASS1,
        EPRG_RES_FAIL_FINAL
    } eprg_res_t;
endpackage : eprg_pkg

// file: rtl/eprg_regs.svh
// Purpose: Constants for the EPROM programming controller
// Assumes: 10 MHz system clock, 100 ns period
// Notes:   Times in ns, counts derived from the clock period
`ifndef EPRG_REGS_SVH
`define EPRG_REGS_SVH
`define EPRG_CLK_NS        100
`define EPRG_ACC_NS        250
`define EPRG_OE_NS         100
`define EPRG_PULSE_NS      1000000
`define EPRG_OVER_NS       2000000
`define EPRG_SETUP_NS      2000
`define EPRG_ACC_CYC  ((`EPRG_ACC_NS + `EPRG_CLK_NS - 1) / `EPRG_CLK_NS)
`define EPRG_SETUP_CYC ((`EPRG_SETUP_NS + `EPRG_CLK_NS - 1) / `EPRG_CLK_NS)
`define EPRG_PULSE_CYC (`EPRG_PULSE_NS / `EPRG_CLK_NS)
`define EPRG_OVER_CYC  (`EPRG_OVER_NS / `EPRG_CLK_NS)
`define EPRG_MAX_PULSES    25
`define EPRG_ERASED_BYTE   8'hff
`define EPRG_ID_SEL_BIT    9
`endif

// file: rtl/eprg_timer.sv
// Purpose: Down counter timing pulses and waits
// Assumes: Single clock, load has priority
// Notes:   o_done pulses one cycle when count reaches zero
`timescale 1ns/1ps
`default_nettype none
module eprg_timer #(
    parameter int W = 16
) (
    input  wire logic         i_sys_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_count,
    output logic              o_busy,
    output logic              o_done
);
    logic [W-1:0] cnt_reg;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_reg <= '0;
        end else if (i_load) begin
            cnt_reg <= i_count;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_done <= 1'b0;
        end else begin
            o_done <= !i_load && (cnt_reg == {{(W-1){1'b0}}, 1'b1});
        end
    end
    assign o_busy = (cnt_reg != '0) || i_load;
endmodule : eprg_timer
`default_nettype wire

// file: verification/eprg_dev_model.sv
// Purpose: Behavioural 64K x 8 UV EPROM facing the controller
// Assumes: Gate supply and identifier voltage arrive as qualifiers
// Notes:   One address may be made to need extra program pulses
`timescale 1ns/1ps
`default_nettype none
module eprg_dev_model #(
    parameter int         ACC_NS   = 250,
    parameter int         OE_NS    = 100,
    parameter int         P1_NS    = 2000,
    parameter int         P2_NS    = 4000,
    parameter logic [7:0] MFR_CODE = 8'h07, // Arbitrary value
    parameter logic [7:0] DEV_CODE = 8'h8c  // Arbitrary value
) (
    input  wire logic [15:0] i_address_lines,
    input  wire logic        i_strobe_n,
    input  wire logic        i_gate_n,
    input  wire logic        i_gate_vpp,
    input  wire logic        i_id_hv,
    input  wire logic [7:0]  i_din,
    input  wire logic        i_din_oe,
    input  wire logic [15:0] i_weak_addr,
    input  wire logic [4:0]  i_weak_need,
    output logic      [7:0]  o_dout
);
    logic [7:0]  mem [65536];
    logic [16:0] sel_q;
    logic        gate_q, en, id_err, clash, po;
    logic [15:0] pa;
    logic [7:0]  pd, code;
    int          sel_age, gate_age, width, hits, p1_cnt, p2_cnt, pulse_cnt;
    // ****************************
    // Pin process, polled off the clock edges
    // ****************************
    initial begin
        foreach (mem[i]) mem[i] = 8'hff;
        {sel_q, gate_q, id_err, clash, o_dout} = '0;
        {sel_age, gate_age, width, hits, p1_cnt, p2_cnt, pulse_cnt} = '0;
        #5;
        forever begin
            #10;
            if ({i_address_lines, i_strobe_n} !== sel_q) sel_age = 5;
            else sel_age += 10;
            if (i_gate_n !== gate_q) gate_age = 5;
            else gate_age += 10;
            sel_q = {i_address_lines, i_strobe_n};
            gate_q = i_gate_n;
            if (!i_strobe_n && i_gate_vpp) begin
                width += 10;
                pa = i_address_lines;
                pd = i_din;
                po = i_din_oe;
            end else if (width > 0) begin
                pulse_cnt++;
                p1_cnt += int'(width == P1_NS);
                p2_cnt += int'(width == P2_NS);
                hits += int'(pa == i_weak_addr);
                if (po && (pa != i_weak_addr || hits >= i_weak_need))
                    mem[pa] = mem[pa] & pd;
                width = 0;
            end
            en = !i_strobe_n && !i_gate_n && !i_gate_vpp;
            if (en && i_id_hv && (i_address_lines & 16'hfdfe) != 16'h0000)
                id_err = 1'b1;
            if (en && i_din_oe) clash = 1'b1;
            code = i_address_lines[0] ? DEV_CODE : MFR_CODE;
            if (en && sel_age >= ACC_NS && gate_age >= OE_NS)
                o_dout = i_id_hv ? code : mem[i_address_lines];
            else
                o_dout = ~o_dout;
        end
    end
endmodule : eprg_dev_model
`default_nettype wire

// file: verification/tb.sv
// Purpose: Self-checking bench for the EPROM controller
// Assumes: Pulse counts shortened to 20 and 40 cycles
// Notes:   Device model answers on the data pins
`timescale 1ns/1ps
`default_nettype none
module tb;
    import eprg_pkg::*;
    // ****************************
    // Signals and instances
    // ****************************
    localparam logic [7:0] MFR = 8'h07; // Arbitrary value
    localparam logic [7:0] DEV = 8'h8c; // Arbitrary value
    logic        i_sys_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        i_start = 1'b0;
    eprg_op_t    i_op = EPRG_OP_READ;
    logic [15:0] i_addr = 16'h0000;
    logic [15:0] i_last_addr = 16'h0000;
    logic [7:0]  i_wdata = 8'h00;
    logic [7:0]  pins, dout, o_rdata, o_data_pins_out;
    logic [15:0] o_cur_addr, o_address_lines;
    logic [15:0] weak_addr = 16'hffff;
    logic [4:0]  weak_need = 5'h03;
    logic        o_busy, o_done, o_rdata_parity_ok, o_wdata_req;
    logic        o_chip_select_program_strobe_n, o_output_gate_n;
    logic        o_output_gate_vpp, o_identifier_select_hv, o_data_pins_oe;
    logic        use_tbl = 1'b0;
    eprg_res_t   o_result;
    logic [7:0]  tbl [4] = '{8'h5a, 8'ha5, 8'h3c, 8'h00};
    int          mismatches = 0;
    int          checked = 0;
    always #50 i_sys_clk = ~i_sys_clk;
    assign pins = o_data_pins_oe ? o_data_pins_out : dout;
    always @(posedge i_sys_clk)
        if (use_tbl) i_wdata <= tbl[2'(o_cur_addr[1:0] + 2'h1)];
    eprg_ctrl #(.PULSE_CYC(20), .OVER_CYC(40)) i_eprg_ctrl (
        .i_sys_clk, .i_rst_n, .i_start, .i_op, .i_addr, .i_last_addr,
        .i_wdata, .i_data_pins_in(pins), .o_busy, .o_done, .o_result,
        .o_rdata, .o_rdata_parity_ok, .o_cur_addr, .o_wdata_req,
        .o_address_lines, .o_chip_select_program_strobe_n,
        .o_output_gate_n, .o_output_gate_vpp, .o_identifier_select_hv,
        .o_data_pins_out, .o_data_pins_oe);
    eprg_dev_model #(.P1_NS(2000), .P2_NS(4000), .MFR_CODE(MFR),
        .DEV_CODE(DEV)) i_eprg_dev_model (
        .i_address_lines(o_address_lines),
        .i_strobe_n(o_chip_select_program_strobe_n),
        .i_gate_n(o_output_gate_n), .i_gate_vpp(o_output_gate_vpp),
        .i_id_hv(o_identifier_select_hv), .i_din(o_data_pins_out),
        .i_din_oe(o_data_pins_oe), .i_weak_addr(weak_addr),
        .i_weak_need(weak_need), .o_dout(dout));
    // ****************************
    // Tasks and scenarios
    // ****************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test
    task automatic run(input eprg_op_t op, input logic [15:0] a,
                       input logic [15:0] la, input logic [7:0] wd,
                       input logic on);
        int n;
        repeat (2) @(posedge i_sys_clk);
        i_op <= op;
        i_addr <= a;
        i_last_addr <= la;
        i_wdata <= wd;
        i_start <= 1'b1;
        @(posedge i_sys_clk);
        i_start <= 1'b0;
        use_tbl <= on;
        n = 0;
        do begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end while (o_done !== 1'b1 && n < 5000);
        use_tbl <= 1'b0;
        if (n >= 5000) begin
            mismatches++;
            stop_test;
        end
        check({o_busy, o_wdata_req}, 16'h0002);
        @(posedge i_sys_clk);
        #1;
        check({o_busy, o_wdata_req}, 16'h0001);
    endtask : run
    task automatic t_ident;
        for (int b = 0; b < 2; b++) begin
            run(EPRG_OP_IDENT, 16'(b), 16'h0000, 8'h00, 1'b0);
            check(o_rdata, b ? DEV : MFR);
            check(o_rdata_parity_ok, 1'b1);
        end
        check(i_eprg_dev_model.id_err, 1'b0);
        $display("Test ident done");
    endtask : t_ident
    task automatic t_prog;
        int p1, p2, pn;
        p1 = i_eprg_dev_model.p1_cnt;
        p2 = i_eprg_dev_model.p2_cnt;
        pn = i_eprg_dev_model.pulse_cnt;
        weak_addr = 16'h0011;
        run(EPRG_OP_PROGRAM, 16'h0010, 16'h0013, tbl[0], 1'b1);
        check(o_result, EPRG_RES_OK);
        check(16'(i_eprg_dev_model.p1_cnt - p1), 16'h0006);
        check(16'(i_eprg_dev_model.p2_cnt - p2), 16'h0004);
        check(16'(i_eprg_dev_model.pulse_cnt - pn), 16'h000a);
        for (int i = 0; i < 4; i++) begin
            run(EPRG_OP_READ, 16'h0010 + 16'(i), 16'h0000, 8'h00, 1'b0);
            check(o_rdata, tbl[i]);
        end
        $display("Test program done");
    endtask : t_prog
    task automatic t_fail;
        int pn;
        pn = i_eprg_dev_model.pulse_cnt;
        run(EPRG_OP_PROGRAM, 16'h0010, 16'h0010, 8'hff, 1'b0);
        check(o_result, EPRG_RES_FAIL_PASS1);
        check(16'(i_eprg_dev_model.pulse_cnt - pn), 16'h0019);
        check(o_cur_addr, 16'h0010);
        run(EPRG_OP_READ, 16'h0010, 16'h0000, 8'h00, 1'b0);
        check(o_rdata, tbl[0]);
        check(i_eprg_dev_model.clash, 1'b0);
        run(EPRG_OP_PROGRAM, 16'h0020, 16'h0020, tbl[0], 1'b1);
        check(o_result, EPRG_RES_FAIL_FINAL);
        check(o_rdata, 8'h00);
        $display("Test failing address done");
    endtask : t_fail
    initial begin
        repeat (3) @(posedge i_sys_clk);
        check({o_chip_select_program_strobe_n, o_output_gate_n,
               o_output_gate_vpp, o_identifier_select_hv,
               o_data_pins_oe, o_busy}, 16'h0030);
        $display("Test reset done");
        i_rst_n <= 1'b1;
        run(EPRG_OP_READ, 16'h1234, 16'h0000, 8'h00, 1'b0);
        check(o_rdata, 8'hff);
        $display("Test read done");
        t_ident;
        t_prog;
        t_fail;
        stop_test;
    end
endmodule : tb
`default_nettype wire
